// file: rtl/tcw_regs.vh
// Purpose: Offsets, field positions and codes of the timer channel block
// Assumes: Included by rtl/tcw_top.v only
// Notes: Three channels at a stride of 0x40, block registers at 0xC0
//
// Overview of operation
// RQ1 - Capture trigger: line A/B, edge select, 0 off
// RQ2 - Generation mode drives A; B unless event source
// RQ3 - One/two PWM outputs, or single/repeating pulses
// RQ4 - A, B, C compare in every count shape
// RQ5 - Shape 00 counts 0 to 0xFFFF, wraps
// RQ6 - Shape 00: event/software trigger resets; no C-trigger
// RQ7 - C match stops and/or disables counter clock
// RQ8 - Shape 10 counts to compare C, resets
// RQ9 - Shape 10: enabled triggers reset counter anytime
// RQ10 - Shape 01 counts up to 0xFFFF, down, repeats
// RQ11 - Shape 11 counts up to C, down, repeats
// RQ12 - Up/down shapes: trigger reverses counting direction
// RQ13 - Event source: ext clocks or line B; edge field
// RQ14 - Source 0: line B input, compare B silent
// RQ15 - Outside event triggers only when enable bit set
// RQ16 - Group start and software trigger always usable
// RQ17 - Output controller set/clear/toggle per event field
// RQ18 - Decoder disabled leaves channels fully unchanged
// RQ19 - Decoder uses ch0 A/B, ch1 A index
// RQ20 - Software selects ext clock 0; routing ignored
// RQ21 - Position: ch0 counts edges, ch1 counts index
// RQ22 - Decoding C match sets compare C flag
// RQ23 - Trigger zeroes counter and starts enabled clock
// RQ24 - Triggers act at next counting clock edge
// RQ25 - Compare flags set status, maskable to interrupt
`ifndef TCW_REGS_VH
`define TCW_REGS_VH

// ****************************************************************
// Register offsets (per channel and block, within 0x40 stride)
// ****************************************************************
`define TCW_OFF_CTRL 6'h00
`define TCW_OFF_MODE 6'h04
`define TCW_OFF_CV 6'h10
`define TCW_OFF_RA 6'h14
`define TCW_OFF_RB 6'h18
`define TCW_OFF_RC 6'h1C
`define TCW_OFF_SR 6'h20
`define TCW_OFF_IMR 6'h24
`define TCW_BLK_IDX 2'h3
`define TCW_OFF_BCR 6'h00
`define TCW_OFF_BMR 6'h04

// ****************************************************************
// Control register bits
// ****************************************************************
`define TCW_CCR_CLKEN 0
`define TCW_CCR_CLKDIS 1
`define TCW_CCR_SOFTWARE_TRIGGER_CMD 2
`define TCW_BCR_SYNC 0
`define TCW_BMR_QUADRATURE_DECODE_ENABLE 8
`define TCW_BMR_POSEN 9
`define TCW_BMR_SPEEDEN 10

// ****************************************************************
// Channel mode register fields
// ****************************************************************
`define TCW_MR_CLKS 2:0
`define TCW_MR_CMPC_STOP_CLOCK 6
`define TCW_MR_CMPC_DISABLE_CLOCK 7
`define TCW_MR_EDGE 9:8
`define TCW_MR_ABSEL 10
`define TCW_MR_EVSRC 11:10
`define TCW_MR_OUTSIDE_EVENT_TRIGGER_ENABLE 12
`define TCW_MR_SHAPE 14:13
`define TCW_MR_WAVE 15
`define TCW_MR_ACPA 17:16
`define TCW_MR_ACPC 19:18
`define TCW_MR_AEEVT 21:20
`define TCW_MR_ASWTRG 23:22
`define TCW_MR_BCPB 25:24
`define TCW_MR_BCPC 27:26
`define TCW_MR_BEEVT 29:28
`define TCW_MR_BSWTRG 31:30
`define TCW_CLKS_EXT0 3'h5

// ****************************************************************
// Status bits, reset values, bus answers
// ****************************************************************
`define TCW_SR_CPA 2
`define TCW_SR_CPB 3
`define TCW_SR_CPC 4
`define TCW_SR_ETRG 7
`define TCW_SR_CLKSTA 16
`define TCW_RST_WORD 32'h00000000
`define TCW_RST_HALF 16'h0000
`define TCW_RESP_OKAY 2'h0
`define TCW_RESP_DECERR 2'h3
`define TCW_CV_MAX 16'hFFFF

`endif

// file: rtl/tcw_top.v
// Purpose: Three timer channels with waveform output and quadrature front end
// Assumes: All pin inputs synchronous to aclk; one AXI4-Lite access at a time
// Notes: Line outputs use active-low enables; flags clear on status read
`timescale 1ns/10ps
`include "tcw_regs.vh"

module tcw_top (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire ext_clock_in_0,
	input wire ext_clock_in_1,
	input wire ext_clock_in_2,
	input wire [2:0] channel_line_a_in,
	output wire [2:0] channel_line_a_out,
	output wire [2:0] channel_line_a_oe_n,
	input wire [2:0] channel_line_b_in,
	output wire [2:0] channel_line_b_out,
	output wire [2:0] channel_line_b_oe_n,
	output wire [2:0] chan_irq
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Edge field: 1 rising, 2 falling, 3 both, 0 none
	function edge_hit;
		input [1:0] sel;
		input prev;
		input cur;
		begin
			edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
		end
	endfunction

	// Output action: 1 set, 2 clear, 3 toggle, 0 keep
	function line_act;
		input cur;
		input [1:0] code;
		begin
			case (code)
				2'h1: line_act = 1'b1;
				2'h2: line_act = 1'b0;
				2'h3: line_act = ~cur;
				default: line_act = cur;
			endcase
		end
	endfunction

	// Internal prescaled tick; divisors 2, 8, 32, 128, 1024
	function presc_tick;
		input [2:0] src;
		input [9:0] pre;
		begin
			case (src)
				3'h0: presc_tick = pre[0];
				3'h1: presc_tick = &pre[2:0];
				3'h2: presc_tick = &pre[4:0];
				3'h3: presc_tick = &pre[6:0];
				3'h4: presc_tick = &pre[9:0];
				default: presc_tick = 1'b0;
			endcase
		end
	endfunction

	// Byte-lane merge for partial writes
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer k;
		begin
			lane_merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					lane_merge[8*k +: 8] = nw[8*k +: 8];
		end
	endfunction

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************
	reg aw_got_q;
	reg w_got_q;
	reg [7:0] wr_addr_q;
	reg [31:0] wr_data_q;
	reg [3:0] wr_strb_q;
	wire wr_en;
	wire rd_fire;

	assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;
	// Write happens once both halves are held; address and data in any order
	assign wr_en = aw_got_q & w_got_q & ~s_axi_bvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= `TCW_RST_WORD;
			wr_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TCW_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				wr_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wr_data_q <= s_axi_wdata;
				wr_strb_q <= s_axi_wstrb;
			end
			if (wr_en)
			begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr_q[1:0] == 2'h0) ? `TCW_RESP_OKAY : `TCW_RESP_DECERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Block controls, prescaler, shared input edges
	// ****************************************************************
	reg [31:0] bmr_q;
	reg [9:0] pre_q;
	reg [2:0] xc_prev_q;
	reg qa_prev_q;
	reg qb_prev_q;
	reg idx_prev_q;
	reg quad_up_q;
	wire blk_sel = wr_en && (wr_addr_q[7:6] == `TCW_BLK_IDX);
	wire sync_trg = blk_sel && (wr_addr_q[5:0] == `TCW_OFF_BCR) && wr_data_q[`TCW_BCR_SYNC];
	wire quadrature_decode_enable = bmr_q[`TCW_BMR_QUADRATURE_DECODE_ENABLE];
	wire posen = quadrature_decode_enable & bmr_q[`TCW_BMR_POSEN];
	wire speeden = quadrature_decode_enable & bmr_q[`TCW_BMR_SPEEDEN];
	wire [2:0] xc_now = {ext_clock_in_2, ext_clock_in_1, ext_clock_in_0};
	wire [2:0] xc_rise = xc_now & ~xc_prev_q;
	wire quad_a = channel_line_a_in[0];
	wire quad_b = channel_line_b_in[0];
	wire quad_idx = channel_line_a_in[1];
	wire phase_edge = (quad_a ^ qa_prev_q) | (quad_b ^ qb_prev_q);
	wire quad_dir = qa_prev_q ^ quad_b;
	// Direction of this very edge, so a reversal never miscounts once
	wire quad_up = phase_edge ? quad_dir : quad_up_q;
	wire idx_rise = quad_idx & ~idx_prev_q;

	// Decoder front end: phase inputs from ch0 lines, index from ch1 line A [RQ19]
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bmr_q <= `TCW_RST_WORD;
			pre_q <= 10'h000;
			xc_prev_q <= 3'h0;
			qa_prev_q <= 1'b0;
			qb_prev_q <= 1'b0;
			idx_prev_q <= 1'b0;
			quad_up_q <= 1'b1;
		end
		else
		begin
			if (blk_sel && (wr_addr_q[5:0] == `TCW_OFF_BMR))
				bmr_q <= lane_merge(bmr_q, wr_data_q, wr_strb_q);
			pre_q <= pre_q + 10'h001;
			xc_prev_q <= xc_now;
			qa_prev_q <= quad_a;
			qb_prev_q <= quad_b;
			idx_prev_q <= quad_idx;
			if (phase_edge)
				quad_up_q <= quad_dir;
		end
	end

	// ****************************************************************
	// Channels
	// ****************************************************************
	wire [3*16-1:0] cv_w;
	wire [3*16-1:0] ra_w;
	wire [3*16-1:0] rb_w;
	wire [3*16-1:0] rc_w;
	wire [3*32-1:0] cmr_w;
	wire [3*32-1:0] sr_w;
	wire [3*8-1:0] imr_w;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_chan
			reg [31:0] cmr_q;
			reg [15:0] cv_q;
			reg [15:0] ra_q;
			reg [15:0] rb_q;
			reg [15:0] rc_q;
			reg [7:0] sr_q;
			reg [7:0] imr_q;
			reg en_q;
			reg run_q;
			reg up_q;
			reg pend_q;
			reg evt_prev_q;
			reg la_q;
			reg lb_q;
			wire csel = wr_en && (wr_addr_q[7:6] == gi);
			wire [5:0] woff = wr_addr_q[5:0];
			wire wave = cmr_q[`TCW_MR_WAVE];
			wire [1:0] shape = cmr_q[`TCW_MR_SHAPE];
			wire b_is_evt = wave && (cmr_q[`TCW_MR_EVSRC] == 2'h0);
			// Speed mode feeds the ch2 time base back onto ch0 line A
			wire la_in = (gi == 0 && speeden) ? g_chan[2].la_q : channel_line_a_in[gi];
			wire ctrl_wr = csel && (woff == `TCW_OFF_CTRL);
			// Software and group start triggers stay usable in every mode [RQ16]
			wire sw_trg = (ctrl_wr && wr_data_q[`TCW_CCR_SOFTWARE_TRIGGER_CMD]) || sync_trg;
			reg evt_sig;
			// Capture: line select picks A or B [RQ1]; waveform: event source [RQ13]
			always @*
			begin
				evt_sig = cmr_q[`TCW_MR_ABSEL] ? la_in : channel_line_b_in[gi];
				if (wave)
				begin
					case (cmr_q[`TCW_MR_EVSRC])
						2'h0: evt_sig = channel_line_b_in[gi];
						2'h1: evt_sig = ext_clock_in_0;
						2'h2: evt_sig = ext_clock_in_1;
						default: evt_sig = ext_clock_in_2;
					endcase
				end
			end
			// Edge 0 never raises the event [RQ1] [RQ13]
			wire ext_evt = edge_hit(cmr_q[`TCW_MR_EDGE], evt_prev_q, evt_sig);
			// Waveform event triggers only with its enable bit [RQ15]
			wire ext_trg = ext_evt && (!wave || cmr_q[`TCW_MR_OUTSIDE_EVENT_TRIGGER_ENABLE]);
			// Decoder overrides the clock choice only when enabled [RQ18] [RQ20]
			wire quad_ch = (gi == 0 && posen) || (gi == 1 && quadrature_decode_enable);
			wire quad_tick = (gi == 0) ? (phase_edge | idx_rise) : idx_rise;
			wire src_tick = (cmr_q[`TCW_MR_CLKS] >= `TCW_CLKS_EXT0)
				? xc_rise[cmr_q[1:0] - 2'h1] : presc_tick(cmr_q[`TCW_MR_CLKS], pre_q);
			wire tick = quad_ch ? quad_tick : src_tick;
			wire cnt = tick && en_q && run_q && !pend_q;
			// Every count shape compares against all three registers [RQ4]
			wire cpa = cnt && (cv_q == ra_q);
			wire cpb = cnt && (cv_q == rb_q) && !b_is_evt; // [RQ14]
			wire cpc = cnt && (cv_q == rc_q); // [RQ22]
			wire [15:0] top = shape[1] ? rc_q : `TCW_CV_MAX;
			reg [15:0] cv_d;
			reg up_d;

			// Next count per shape
			always @*
			begin
				cv_d = cv_q;
				up_d = up_q;
				if (quad_ch)
				begin
					// Position/index counting follows decoded direction [RQ21]
					cv_d = quad_up ? cv_q + 16'h0001 : cv_q - 16'h0001;
					if (gi == 0 && idx_rise)
						cv_d = `TCW_RST_HALF;
				end
				else if (!wave || shape == 2'h0)
					cv_d = cv_q + 16'h0001; // Wraps at 0xFFFF [RQ5]
				else if (shape == 2'h2)
					cv_d = (cv_q == rc_q) ? `TCW_RST_HALF : cv_q + 16'h0001; // [RQ8]
				else if (up_q)
				begin
					// Turn at 0xFFFF or compare C [RQ10] [RQ11]
					if (cv_q >= top)
					begin
						up_d = 1'b0;
						cv_d = cv_q - 16'h0001;
					end
					else
						cv_d = cv_q + 16'h0001;
				end
				else if (cv_q == `TCW_RST_HALF)
				begin
					up_d = 1'b1;
					cv_d = 16'h0001;
				end
				else
					cv_d = cv_q - 16'h0001;
			end

			// Counter, clock control and compare flags
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					cmr_q <= `TCW_RST_WORD;
					cv_q <= `TCW_RST_HALF;
					ra_q <= `TCW_RST_HALF;
					rb_q <= `TCW_RST_HALF;
					rc_q <= `TCW_RST_HALF;
					sr_q <= 8'h00;
					imr_q <= 8'h00;
					en_q <= 1'b0;
					run_q <= 1'b0;
					up_q <= 1'b1;
					pend_q <= 1'b0;
					evt_prev_q <= 1'b0;
				end
				else
				begin
					evt_prev_q <= evt_sig;
					if (csel && woff == `TCW_OFF_MODE)
						cmr_q <= lane_merge(cmr_q, wr_data_q, wr_strb_q);
					if (csel && woff == `TCW_OFF_RA)
						ra_q <= wr_data_q[15:0];
					if (csel && woff == `TCW_OFF_RB)
						rb_q <= wr_data_q[15:0];
					if (csel && woff == `TCW_OFF_RC)
						rc_q <= wr_data_q[15:0];
					if (csel && woff == `TCW_OFF_IMR)
						imr_q <= wr_data_q[7:0];
					// Triggers wait for the next counting clock edge [RQ24]
					if (sw_trg || ext_trg)
						pend_q <= 1'b1;
					else if (tick)
						pend_q <= 1'b0;
					if (tick && pend_q)
					begin
						if (en_q)
							run_q <= 1'b1; // [RQ23]
						if (wave && shape[0])
							up_q <= ~up_q; // Reverse instead of zeroing [RQ12]
						else
							cv_q <= `TCW_RST_HALF; // [RQ6] [RQ9] [RQ23]
					end
					else if (cnt)
					begin
						cv_q <= cv_d;
						up_q <= up_d;
					end
					// Compare C may stop and disable together [RQ7]
					if (cpc && wave && cmr_q[`TCW_MR_CMPC_STOP_CLOCK])
						run_q <= 1'b0;
					if (ctrl_wr && wr_data_q[`TCW_CCR_CLKEN])
						en_q <= 1'b1;
					if ((cpc && wave && cmr_q[`TCW_MR_CMPC_DISABLE_CLOCK])
						|| (ctrl_wr && wr_data_q[`TCW_CCR_CLKDIS]))
					begin
						en_q <= 1'b0;
						run_q <= 1'b0;
					end
					// Sticky flags; a new event beats the read clear [RQ25]
					sr_q <= (sr_q & {8{~(rd_fire && s_axi_araddr[7:6] == gi
						&& s_axi_araddr[5:0] == `TCW_OFF_SR)}})
						| ({7'h00, cpa} << `TCW_SR_CPA)
						| ({7'h00, cpb} << `TCW_SR_CPB)
						| ({7'h00, cpc} << `TCW_SR_CPC)
						| ({7'h00, ext_trg} << `TCW_SR_ETRG);
				end
			end

			// Output controller, priority software > event > C > A/B [RQ17]
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					la_q <= 1'b0;
					lb_q <= 1'b0;
				end
				else if (wave)
				begin
					// PWM duty from A/B compares, period from C [RQ3]
					la_q <= line_act(line_act(line_act(line_act(la_q,
						cpa ? cmr_q[`TCW_MR_ACPA] : 2'h0),
						cpc ? cmr_q[`TCW_MR_ACPC] : 2'h0),
						ext_evt ? cmr_q[`TCW_MR_AEEVT] : 2'h0),
						sw_trg ? cmr_q[`TCW_MR_ASWTRG] : 2'h0);
					if (!b_is_evt)
						lb_q <= line_act(line_act(line_act(line_act(lb_q,
							cpb ? cmr_q[`TCW_MR_BCPB] : 2'h0),
							cpc ? cmr_q[`TCW_MR_BCPC] : 2'h0),
							ext_evt ? cmr_q[`TCW_MR_BEEVT] : 2'h0),
							sw_trg ? cmr_q[`TCW_MR_BSWTRG] : 2'h0);
				end
			end

			// Line A driven in waveform; B unless it is the event input [RQ2] [RQ14]
			assign channel_line_a_out[gi] = la_q;
			assign channel_line_b_out[gi] = lb_q;
			assign channel_line_a_oe_n[gi] = ~wave;
			assign channel_line_b_oe_n[gi] = ~wave | b_is_evt;
			assign chan_irq[gi] = |(sr_q & imr_q); // [RQ25]
			assign cv_w[16*gi +: 16] = cv_q;
			assign ra_w[16*gi +: 16] = ra_q;
			assign rb_w[16*gi +: 16] = rb_q;
			assign rc_w[16*gi +: 16] = rc_q;
			assign cmr_w[32*gi +: 32] = cmr_q;
			assign sr_w[32*gi +: 32] = {15'h0000, en_q, 8'h00, sr_q};
			assign imr_w[8*gi +: 8] = imr_q;
		end
	endgenerate

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************
	reg [31:0] rd_mux;
	reg rd_ok;
	wire [1:0] rch = s_axi_araddr[7:6];
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;

	// Unmapped or unaligned reads answer DECERR with zero data
	always @*
	begin
		rd_mux = `TCW_RST_WORD;
		rd_ok = (s_axi_araddr[1:0] == 2'h0);
		if (rch == `TCW_BLK_IDX)
		begin
			if (s_axi_araddr[5:0] == `TCW_OFF_BMR)
				rd_mux = bmr_q;
			else if (s_axi_araddr[5:0] != `TCW_OFF_BCR)
				rd_ok = 1'b0;
		end
		else
		begin
			case (s_axi_araddr[5:0])
				`TCW_OFF_CTRL: rd_mux = `TCW_RST_WORD;
				`TCW_OFF_MODE: rd_mux = cmr_w[32*rch +: 32];
				`TCW_OFF_CV: rd_mux = {16'h0000, cv_w[16*rch +: 16]};
				`TCW_OFF_RA: rd_mux = {16'h0000, ra_w[16*rch +: 16]};
				`TCW_OFF_RB: rd_mux = {16'h0000, rb_w[16*rch +: 16]};
				`TCW_OFF_RC: rd_mux = {16'h0000, rc_w[16*rch +: 16]};
				`TCW_OFF_SR: rd_mux = sr_w[32*rch +: 32];
				`TCW_OFF_IMR: rd_mux = {24'h000000, imr_w[8*rch +: 8]};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `TCW_RST_WORD;
			s_axi_rresp <= `TCW_RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_ok ? rd_mux : `TCW_RST_WORD;
			s_axi_rresp <= rd_ok ? `TCW_RESP_OKAY : `TCW_RESP_DECERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

// file: bench/tcw_partner.sv
// Purpose: Far-side model: rotary sensor phases, index and event pulses
// Assumes: Pins resolve with device drive winning where its enable is low
// Notes: Event clock lines stand still between pulses
`timescale 1ns/10ps

module tcw_partner (
	input wire aclk,
	output wire ext_clock_in_0,
	output wire ext_clock_in_1,
	output wire ext_clock_in_2,
	output wire [2:0] channel_line_a_in,
	input wire [2:0] channel_line_a_out,
	input wire [2:0] channel_line_a_oe_n,
	output wire [2:0] channel_line_b_in,
	input wire [2:0] channel_line_b_out,
	input wire [2:0] channel_line_b_oe_n
);
	// ********
	// Pin drive
	// ********
	logic [2:0] ev = 3'h0;
	logic pa = 1'h0;
	logic pb = 1'h0;
	logic hz = 1'h0;

	// Undriven lines wander so a stale level never passes for a driven one
	always @(posedge aclk)
		hz <= ~hz;

	// Sensor holds phases on channel 0 and index on channel 1 line A
	assign channel_line_a_in = ~channel_line_a_oe_n & channel_line_a_out
		| channel_line_a_oe_n & {hz, ev[2], pa};
	assign channel_line_b_in = ~channel_line_b_oe_n & channel_line_b_out
		| channel_line_b_oe_n & {hz, hz, pb};
	assign ext_clock_in_0 = ev[0];
	assign ext_clock_in_1 = ev[1];
	assign ext_clock_in_2 = 1'h0;

	// Pulses wide enough for the edge detectors, 0 ext clock, 1 event, 2 index
	task pulse(input int s, input int n);
		repeat (n)
		begin
			@(posedge aclk);
			ev[s] <= 1'h1;
			repeat (3) @(posedge aclk);
			ev[s] <= 1'h0;
			repeat (3) @(posedge aclk);
		end
	endtask

	// Gray steps on the two phases, one line changing per step
	task quad(input int n, input bit fwd);
		repeat (n)
		begin
			@(posedge aclk);
			if ((pa == pb) == fwd)
				pa <= ~pa;
			else
				pb <= ~pb;
			repeat (3) @(posedge aclk);
		end
	endtask
endmodule

// file: bench/tcw_assertions.sv
// Purpose: Bus and pin relations of the timer block seen at its ports
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/10ps

module tcw_assertions (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [2:0] channel_line_a_oe_n,
	input wire [2:0] channel_line_b_oe_n,
	input wire [2:0] chan_irq
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Answers hold until taken; the write answer then drops at once
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	// No new request taken while an answer waits
	chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	chk_ar_rule: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read ready wrong");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	chk_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |->
		s_axi_rdata == 32'h0) else $error("error read carries data");
	// Line B never driven while line A is released
	chk_b_needs_a: assert property ((~channel_line_b_oe_n & channel_line_a_oe_n) == 3'h0)
		else $error("line B driven without line A");
	chk_reset_quiet: assert property ($rose(aresetn) |-> channel_line_a_oe_n == 3'h7
		&& channel_line_b_oe_n == 3'h7 && chan_irq == 3'h0) else $error("pins not idle");

	// Main scenarios reached
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_decerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
	cov_irq: cover property ($rose(chan_irq[0]));
	cov_b_free: cover property (!channel_line_a_oe_n[0] && channel_line_b_oe_n[0]);
endmodule

bind tcw_top tcw_assertions tcw_assertions_inst (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.channel_line_a_oe_n, .channel_line_b_oe_n, .chan_irq);

// file: bench/tb.sv
// Purpose: Self-checking bench for the timer channel block
// Assumes: Partner model plays the sensor and event pins
// Notes: Counts advance only on partner pulses, so values are exact
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module tb;
	// ********
	// Signals and instances
	// ********
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rdv, v0, v1;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [1:0] rsp;
	logic [7:0] zr [8] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'hC4};
	int err_count = 0, cmp_count = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire ext_clock_in_0, ext_clock_in_1, ext_clock_in_2;
	wire [2:0] channel_line_a_in, channel_line_a_out, channel_line_a_oe_n, chan_irq;
	wire [2:0] channel_line_b_in, channel_line_b_out, channel_line_b_oe_n;

	tcw_top tcw_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clock_in_0, .ext_clock_in_1,
		.ext_clock_in_2, .channel_line_a_in, .channel_line_a_out, .channel_line_a_oe_n,
		.channel_line_b_in, .channel_line_b_out, .channel_line_b_oe_n, .chan_irq);
	tcw_partner tcw_partner_inst (.aclk, .ext_clock_in_0, .ext_clock_in_1, .ext_clock_in_2,
		.channel_line_a_in, .channel_line_a_out, .channel_line_a_oe_n, .channel_line_b_in,
		.channel_line_b_out, .channel_line_b_oe_n);

	// 250 MHz clock
	initial
		forever #2 aclk = ~aclk;

	// Write: both halves offered together, each dropped once taken
	task wr(input [7:0] a, input [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask

	// Read: data and code taken at the edge where rvalid is seen
	task rd(input [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask

	task cv_is(input [31:0] e);
		rd(8'h10);
		`CHK("counter", e, rdv)
	endtask

	task pl(input int s, input int n);
		tcw_partner_inst.pulse(s, n);
	endtask

	task qd(input int n, input bit f);
		tcw_partner_inst.quad(n, f);
	endtask

	task tally_and_finish;
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard, far beyond the several hundred cycles the tests need
	initial
	begin
		#40000;
		err_count++;
		tally_and_finish;
	end

	// ********
	// Test sequence
	// ********
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (zr[i])
		begin
			rd(zr[i]);
			`CHK("reset value", 32'h0, rdv)
		end
		rd(8'h08);
		`CHK("unmapped read", 34'h300000000, {rsp, rdv})
		wr(8'h02, 32'h0);
		`CHK("unaligned write", 2'h3, rsp)
		// Capture trigger from line A, then with the edge field cleared
		wr(8'h44, 32'h505);
		rd(8'h60);
		pl(2, 1);
		rd(8'h60);
		`CHK("capture trigger", 1'h1, rdv[7])
		wr(8'h44, 32'h405);
		pl(2, 1);
		rd(8'h60);
		`CHK("capture off", 1'h0, rdv[7])
		// Up to compare C, toggle A on C, set both lines on software trigger
		wr(8'h1C, 32'h3);
		wr(8'h24, 32'h10);
		wr(8'h04, 32'h404CD905);
		rd(8'h04);
		`CHK("mode", 32'h404CD905, rdv)
		`CHK("drives", 2'h0, {channel_line_a_oe_n[0], channel_line_b_oe_n[0]})
		wr(8'h00, 32'h5);
		@(posedge aclk);
		`CHK("sw set", 2'h3, {channel_line_a_out[0], channel_line_b_out[0]})
		rd(8'h20);
		`CHK("clock on", 1'h1, rdv[16])
		pl(0, 3);
		cv_is(32'h2);
		pl(0, 1);
		cv_is(32'h3);
		pl(0, 1);
		cv_is(32'h0);
		`CHK("toggle on C", 2'h1, {channel_line_a_out[0], chan_irq[0]})
		rd(8'h20);
		`CHK("C flag", 1'h1, rdv[4])
		`CHK("irq clear", 1'h0, chan_irq[0])
		// Outside event as trigger, group start, then event trigger disabled
		pl(0, 2);
		pl(1, 1);
		cv_is(32'h2);
		rd(8'h20);
		`CHK("event flag", 1'h1, rdv[7])
		pl(0, 1);
		cv_is(32'h0);
		pl(0, 2);
		wr(8'hC0, 32'h1);
		pl(0, 1);
		cv_is(32'h0);
		wr(8'h04, 32'h404CC905);
		pl(0, 2);
		pl(1, 1);
		pl(0, 1);
		cv_is(32'h3);
		// Free-running shape, compare C disables the clock
		wr(8'h04, 32'h404C8985);
		wr(8'h00, 32'h4);
		pl(0, 5);
		rd(8'h20);
		`CHK("clock off", 1'h0, rdv[16])
		rd(8'h10);
		v0 = rdv;
		`CHK("no C reset", 1'h0, v0 == 32'h0)
		pl(0, 2);
		cv_is(v0);
		// Line B as event source, up/down to compare C, compare B masked out
		wr(8'h24, 32'h8);
		wr(8'h04, 32'h404CE105);
		`CHK("line B free", 2'h1, {channel_line_a_oe_n[0], channel_line_b_oe_n[0]})
		rd(8'h20);
		wr(8'h00, 32'h5);
		pl(0, 6);
		cv_is(32'h1);
		`CHK("B silent", 1'h0, chan_irq[0])
		rd(8'h20);
		`CHK("B flag", 2'h2, rdv[4:3])
		// Quadrature decoding in position mode, then decoder off
		wr(8'h1C, 32'h2);
		wr(8'h04, 32'h5);
		wr(8'h44, 32'h5);
		wr(8'hC4, 32'h300);
		wr(8'h00, 32'h5);
		wr(8'h40, 32'h5);
		qd(2, 1);
		rd(8'h10);
		v0 = rdv;
		qd(6, 1);
		rd(8'h10);
		`CHK("edges", 1'h1, rdv[15:0] - v0[15:0] == 16'h6 || v0[15:0] - rdv[15:0] == 16'h6)
		qd(6, 0);
		cv_is(v0);
		rd(8'h20);
		qd(3, 1);
		qd(7, 0);
		rd(8'h20);
		`CHK("decode C flag", 1'h1, rdv[4])
		pl(2, 1);
		rd(8'h50);
		v1 = rdv;
		pl(2, 1);
		cv_is(32'h0);
		rd(8'h50);
		`CHK("index", 1'h1, rdv[15:0] - v1[15:0] == 16'h1 || v1[15:0] - rdv[15:0] == 16'h1)
		wr(8'hC4, 32'h0);
		rd(8'h10);
		v0 = rdv;
		qd(4, 1);
		cv_is(v0);
		tally_and_finish;
	end
endmodule
